// file: rtl/ssc_pkg.sv
// Constants and helpers for the supply SPI control and status block
//
// Behaviour
// - Bits D10D11 pick reset delay 64/32/16/8 ms; default 11.
// - Bits D12D13 pick window length 128/64/32/16 ms; default 00.
// - Watchdog runs only when D0,D9,D14 are 0,1,0; default 101 is off.
// - D15 set to 1 triggers the watchdog, 0 means not triggered.
// - Fault low and D0 set on prewarning, watchdog error, cold start, tracker timeout.
// - D1 shows the live overtemperature prewarning, unlatched.
// - D2 to D7 show live tracker settled status; 0 when off or shorted.
// - D8 and D9 latch start type per regulator; 0 cold, 1 warm.
// - D10 shows the live window phase; 1 means closed window.
// - D11 to D13 show live undervoltage reset of each regulator.
// - D14 latches a watchdog error.
// - Control word shifts in LSB first while status shifts out alongside.
// - Chip select rising adopts a full 16-bit word and releases the data output.
// - Chip select rising after a full 16-bit frame with trigger bit 1 counts as a watchdog trigger.
// - Both start-type flags go to 1 (warm) after each completed transfer.
package ssc_pkg;
   localparam int WORD_W = 16;
   localparam int TRK_N = 6;
   localparam int CNT_W = 5;
   localparam int MS_W = 8;
   // Control word field positions
   localparam int CTL_OFF1_BIT = 0;
   localparam int CTL_SPARE_BIT = 1;
   localparam int CTL_TRK_LSB = 2;
   localparam int CTL_OFF2_BIT = 9;
   localparam int CTL_RES_LSB = 10;
   localparam int CTL_WIN_LSB = 12;
   localparam int CTL_OFF3_BIT = 14;
   localparam int CTL_TRIG_BIT = 15;
   localparam logic [WORD_W-1:0] CTL_RESET = 16'h4DFD;
   // Status word field positions
   localparam int ST_ERR_BIT = 0;
   localparam int ST_TEMP_BIT = 1;
   localparam int ST_TRK_LSB = 2;
   localparam int ST_START_A_BIT = 8;
   localparam int ST_START_B_BIT = 9;
   localparam int ST_WIN_BIT = 10;
   localparam int ST_UV_LSB = 11;
   localparam int ST_WDG_ERR_BIT = 14;
   localparam int ST_DCDC_BIT = 15;
   // Timing
   localparam logic [MS_W-1:0] RES_BASE_MS = 8'h40;
   localparam logic [MS_W-1:0] WIN_BASE_MS = 8'h80;
   localparam int CLK_MHZ = 200;
   localparam int MS_TIME_US = 1000;
   localparam int SETTLE_TIME_US = 1000;
   localparam int CYC_PER_MS = MS_TIME_US * CLK_MHZ;
   localparam int SETTLE_CYC = SETTLE_TIME_US * CLK_MHZ;
   localparam logic [CNT_W-1:0] FULL_CNT = 5'h10;

   // Two-bit timing code halves the base once per step; code is {high bit, low bit}
   function automatic logic [MS_W-1:0] ms_from_code(input logic [MS_W-1:0] base,
                                                   input logic [1:0] code);
      return base >> code;
   endfunction : ms_from_code

   // Only the single pattern 0,1,0 on the three enable bits turns the watchdog on
   function automatic logic wdg_on(input logic [WORD_W-1:0] w);
      return !w[CTL_OFF1_BIT] && w[CTL_OFF2_BIT] && !w[CTL_OFF3_BIT];
   endfunction : wdg_on
endpackage : ssc_pkg

// file: rtl/ssc_sup_if.sv
// Bundle between the register core, the window watchdog and the tracker monitor
`timescale 1ns/1ps
`default_nettype none
interface ssc_sup_if;
   logic wdg_en;
   logic wdg_kick;
   logic [ssc_pkg::MS_W-1:0] win_ms;
   logic win_closed;
   logic wdg_err;
   logic [ssc_pkg::TRK_N-1:0] trk_en;
   logic [ssc_pkg::TRK_N-1:0] trk_ok;
   logic trk_fail;
   modport core (output wdg_en, wdg_kick, win_ms, trk_en, trk_ok,
                 input win_closed, wdg_err, trk_fail);
   modport wdg (input wdg_en, wdg_kick, win_ms, output win_closed, wdg_err);
   modport mon (input trk_en, trk_ok, output trk_fail);
endinterface : ssc_sup_if
`default_nettype wire

// file: rtl/ssc_window_wdg.sv
// Window watchdog: closed window then open window, trigger only valid when open
`timescale 1ns/1ps
`default_nettype none
module ssc_window_wdg #(
   parameter int CYC_PER_MS = ssc_pkg::CYC_PER_MS
) (
   input wire logic i_clk,   // Core clock
   input wire logic i_rst_n, // Async reset, active low
   ssc_sup_if.wdg sup        // Watchdog side of the bundle
);
   localparam int PRE_W = $clog2(CYC_PER_MS + 1);
   typedef enum logic [1:0] {W_IDLE, W_CLOSED, W_OPEN} ssc_wstate_t;

   ssc_wstate_t state_reg;
   logic [PRE_W-1:0] pre_reg;
   logic [ssc_pkg::MS_W-1:0] ms_reg;
   logic [ssc_pkg::MS_W-1:0] len_reg;
   logic err_reg;
   logic tick;
   logic expired;

   // Millisecond prescaler, restarted with every window so windows are whole
   assign tick = (pre_reg == PRE_W'(CYC_PER_MS - 1));
   assign expired = tick && (ms_reg == len_reg - 8'h01);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pre_reg <= '0;
      end else if (tick || state_reg == W_IDLE || sup.wdg_kick || expired) begin
         pre_reg <= '0;
      end else begin
         pre_reg <= pre_reg + PRE_W'(1);
      end
   end

   // Window sequencer; a new length is taken at each closed window start
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= W_IDLE;
         ms_reg <= '0;
         len_reg <= ssc_pkg::WIN_BASE_MS;
         err_reg <= 1'b0;
      end else begin
         err_reg <= 1'b0;
         if (!sup.wdg_en) begin // Disabled: counters held cleared
            state_reg <= W_IDLE;
            ms_reg <= '0;
         end else begin
            case (state_reg)
               W_IDLE: begin
                  state_reg <= W_CLOSED;
                  ms_reg <= '0;
                  len_reg <= sup.win_ms;
               end
               W_CLOSED: begin
                  if (sup.wdg_kick || expired) begin
                     // Early trigger is an error; expiry opens the window
                     err_reg <= sup.wdg_kick;
                     state_reg <= sup.wdg_kick ? W_CLOSED : W_OPEN;
                     ms_reg <= '0;
                     if (sup.wdg_kick) begin
                        len_reg <= sup.win_ms;
                     end
                  end else if (tick) begin
                     ms_reg <= ms_reg + 8'h01;
                  end
               end
               W_OPEN: begin
                  if (sup.wdg_kick || expired) begin
                     // Missing trigger is an error; both restart a closed window
                     err_reg <= !sup.wdg_kick;
                     state_reg <= W_CLOSED;
                     ms_reg <= '0;
                     len_reg <= sup.win_ms;
                  end else if (tick) begin
                     ms_reg <= ms_reg + 8'h01;
                  end
               end
               default: state_reg <= W_IDLE;
            endcase
         end
      end
   end

   assign sup.win_closed = (state_reg == W_CLOSED);
   assign sup.wdg_err = err_reg;
endmodule : ssc_window_wdg
`default_nettype wire

// file: rtl/ssc_settle_mon.sv
// Tracker settle monitor: flags any enabled tracker unsettled for too long
`timescale 1ns/1ps
`default_nettype none
module ssc_settle_mon #(
   parameter int SETTLE_CYC = ssc_pkg::SETTLE_CYC
) (
   input wire logic i_clk,   // Core clock
   input wire logic i_rst_n, // Async reset, active low
   ssc_sup_if.mon sup        // Monitor side of the bundle
);
   localparam int SC_W = $clog2(SETTLE_CYC + 1);
   logic [SC_W-1:0] cnt_reg [ssc_pkg::TRK_N];
   logic [ssc_pkg::TRK_N-1:0] late;

   // One saturating counter per tracker, cleared while off or settled
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < ssc_pkg::TRK_N; i++) begin
            cnt_reg[i] <= '0;
         end
      end else begin
         for (int i = 0; i < ssc_pkg::TRK_N; i++) begin
            if (!sup.trk_en[i] || sup.trk_ok[i]) begin
               cnt_reg[i] <= '0;
            end else if (!late[i]) begin
               cnt_reg[i] <= cnt_reg[i] + SC_W'(1);
            end
         end
      end
   end

   // Timeout flag per tracker
   always_comb begin
      for (int i = 0; i < ssc_pkg::TRK_N; i++) begin
         late[i] = (cnt_reg[i] == SC_W'(SETTLE_CYC));
      end
   end

   assign sup.trk_fail = |late;
endmodule : ssc_settle_mon
`default_nettype wire

// file: rtl/supply_spi_control_status.sv
// Top of the supply SPI control and status block: shifter, control and status words
`timescale 1ns/1ps
`default_nettype none
module supply_spi_control_status #(
   parameter int CYC_PER_MS = ssc_pkg::CYC_PER_MS, // Core cycles per millisecond
   parameter int SETTLE_CYC = ssc_pkg::SETTLE_CYC  // Tracker settle limit in cycles
) (
   input wire logic I_CLK,                              // Core clock, 200 MHz
   input wire logic I_RST_N,                            // Async reset, active low
   input wire logic I_SCLK,                             // SPI shift clock from master
   input wire logic I_CS_N,                             // SPI chip select, active low
   input wire logic I_DI,                               // SPI data in
   output logic O_DO,                                   // SPI data out
   output logic O_DO_OE,                                // Drive enable for data out
   input wire logic I_OVERTEMP,                         // Temperature prewarning
   input wire logic [ssc_pkg::TRK_N-1:0] I_TRK_SETTLED, // Tracker outputs settled
   input wire logic I_RAM_LOST_A,                       // Main 5 V regulator fell low
   input wire logic I_RAM_LOST_B,                       // Second regulator fell low
   input wire logic [2:0] I_UV_RESET,                   // Undervoltage resets a, b, c
   input wire logic I_DCDC_ON,                          // Converter running
   output logic O_ERR_N,                                // Fault output, active low
   output logic [ssc_pkg::WORD_W-1:0] O_CTRL_WORD,      // Current control word
   output logic [ssc_pkg::TRK_N-1:0] O_TRK_EN,          // Tracker enables
   output logic [ssc_pkg::MS_W-1:0] O_RESET_DELAY_MS,   // Reset delay time in ms
   output logic [ssc_pkg::MS_W-1:0] O_WIN_MS,           // Window time in ms
   output logic O_WDG_EN,                               // Watchdog enabled
   output logic O_WDG_ERR                               // Latched watchdog error
);
   localparam int RAW_W = 14;

   ssc_sup_if sup ();

   // ---------------- Link domain, clocked by the master's shift clock
   logic frame_new_reg;
   logic [ssc_pkg::CNT_W-1:0] rx_cnt_reg;
   logic [ssc_pkg::WORD_W-1:0] rx_sr_reg;

   // Set while deselected; the first edge of a frame clears it
   always_ff @(posedge I_SCLK or posedge I_CS_N) begin
      if (I_CS_N) begin
         frame_new_reg <= 1'b1;
      end else begin
         frame_new_reg <= 1'b0;
      end
   end

   // Bit counter restarts on a frame's first edge and keeps its value after
   // the frame, so the core can read it once chip select is high again
   always_ff @(posedge I_SCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rx_cnt_reg <= '0;
      end else if (frame_new_reg) begin
         rx_cnt_reg <= 5'h01;
      end else if (rx_cnt_reg != ssc_pkg::FULL_CNT) begin
         rx_cnt_reg <= rx_cnt_reg + 5'h01;
      end
   end

   // LSB arrives first, so new bits enter at the top
   always_ff @(posedge I_SCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rx_sr_reg <= '0;
      end else begin
         rx_sr_reg <= {I_DI, rx_sr_reg[ssc_pkg::WORD_W-1:1]};
      end
   end

   // ---------------- Core domain
   logic [RAW_W-1:0] raw_meta_reg;
   logic [RAW_W-1:0] raw_reg;
   logic cs_n_s;
   logic cs_n_d_reg;
   logic frame_end;
   logic frame_done;
   logic temp_s;
   logic [ssc_pkg::TRK_N-1:0] trk_s;
   logic lost_a_s;
   logic lost_b_s;
   logic [2:0] uv_s;
   logic dcdc_s;

   // Status pins and chip select pass two flip-flops; the first is read by nothing else
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         raw_meta_reg <= 14'h3000; // Idle levels: deselected, converter on
         raw_reg <= 14'h3000;
      end else begin
         raw_meta_reg <= {I_CS_N, I_DCDC_ON, I_UV_RESET, I_RAM_LOST_B, I_RAM_LOST_A,
                          I_TRK_SETTLED, I_OVERTEMP};
         raw_reg <= raw_meta_reg;
      end
   end

   assign cs_n_s = raw_reg[13];
   assign dcdc_s = raw_reg[12];
   assign uv_s = raw_reg[11:9];
   assign lost_b_s = raw_reg[8];
   assign lost_a_s = raw_reg[7];
   assign trk_s = raw_reg[6:1];
   assign temp_s = raw_reg[0];

   // Delayed chip select for edge detection
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         cs_n_d_reg <= 1'b1;
      end else begin
         cs_n_d_reg <= cs_n_s;
      end
   end

   // The link word and count are stable once chip select is high, since the
   // shift clock has stopped; the synchronised edge qualifies them
   assign frame_end = cs_n_s && !cs_n_d_reg;
   assign frame_done = frame_end && (rx_cnt_reg == ssc_pkg::FULL_CNT);

   // ---------------- Control word
   logic [ssc_pkg::WORD_W-1:0] ctrl_reg;
   logic [ssc_pkg::WORD_W-1:0] ctrl_next;
   logic kick_reg;

   // Spare bit is forced to zero so it can never steer anything
   always_comb begin
      ctrl_next = rx_sr_reg;
      ctrl_next[ssc_pkg::CTL_SPARE_BIT] = 1'b0;
   end

   // Cold start of the main regulator holds defaults; a short frame is dropped
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         ctrl_reg <= ssc_pkg::CTL_RESET;
      end else if (lost_a_s) begin
         ctrl_reg <= ssc_pkg::CTL_RESET;
      end else if (frame_done) begin
         ctrl_reg <= ctrl_next;
      end
   end

   // Trigger is registered one cycle, so the watchdog sees it with the previous window length
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         kick_reg <= 1'b0;
      end else begin
         kick_reg <= frame_done && !lost_a_s && rx_sr_reg[ssc_pkg::CTL_TRIG_BIT];
      end
   end

   // Decoded control outputs, registered
   logic [ssc_pkg::MS_W-1:0] dly_reg;
   logic [ssc_pkg::MS_W-1:0] win_reg;
   logic wdg_en_reg;

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         dly_reg <= ssc_pkg::ms_from_code(ssc_pkg::RES_BASE_MS, 2'h3);
         win_reg <= ssc_pkg::WIN_BASE_MS;
         wdg_en_reg <= 1'b0;
      end else begin
         dly_reg <= ssc_pkg::ms_from_code(ssc_pkg::RES_BASE_MS,
                       ctrl_reg[ssc_pkg::CTL_RES_LSB+:2]);
         win_reg <= ssc_pkg::ms_from_code(ssc_pkg::WIN_BASE_MS,
                       ctrl_reg[ssc_pkg::CTL_WIN_LSB+:2]);
         wdg_en_reg <= ssc_pkg::wdg_on(ctrl_reg);
      end
   end

   // Bundle towards the watchdog and the tracker monitor
   assign sup.wdg_en = wdg_en_reg;
   assign sup.wdg_kick = kick_reg;
   assign sup.win_ms = win_reg;
   assign sup.trk_en = ctrl_reg[ssc_pkg::CTL_TRK_LSB+:ssc_pkg::TRK_N];
   assign sup.trk_ok = trk_s;

   ssc_window_wdg #(
      .CYC_PER_MS(CYC_PER_MS)
   ) u_wdg (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .sup(sup.wdg)
   );

   ssc_settle_mon #(
      .SETTLE_CYC(SETTLE_CYC)
   ) u_mon (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .sup(sup.mon)
   );

   // ---------------- Latched status flags
   logic cold_a_reg;
   logic cold_b_reg;
   logic wdg_err_reg;
   logic err_reg;
   logic err_cond;

   // Cold flags start set; a completed transfer clears them, a drop wins
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         cold_a_reg <= 1'b1;
         cold_b_reg <= 1'b1;
      end else begin
         cold_a_reg <= lost_a_s || (cold_a_reg && !frame_done);
         cold_b_reg <= lost_b_s || (cold_b_reg && !frame_done);
      end
   end

   // Watchdog error holds until read out, new error wins over the clear
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         wdg_err_reg <= 1'b0;
      end else begin
         wdg_err_reg <= sup.wdg_err || (wdg_err_reg && !frame_done);
      end
   end

   // Summary fault; stays while any cause remains
   assign err_cond = temp_s || wdg_err_reg || cold_a_reg || cold_b_reg || sup.trk_fail;

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         err_reg <= 1'b1;
      end else begin
         err_reg <= err_cond || (err_reg && !frame_done);
      end
   end

   // ---------------- Status word
   logic [ssc_pkg::WORD_W-1:0] stat;
   logic [ssc_pkg::WORD_W-1:0] snap_reg;

   always_comb begin
      stat = '0;
      stat[ssc_pkg::ST_ERR_BIT] = err_reg;
      stat[ssc_pkg::ST_TEMP_BIT] = temp_s;
      stat[ssc_pkg::ST_TRK_LSB+:ssc_pkg::TRK_N] = trk_s & sup.trk_en;
      stat[ssc_pkg::ST_START_A_BIT] = !cold_a_reg;
      stat[ssc_pkg::ST_START_B_BIT] = !cold_b_reg;
      stat[ssc_pkg::ST_WIN_BIT] = sup.win_closed;
      stat[ssc_pkg::ST_UV_LSB+:3] = uv_s;
      stat[ssc_pkg::ST_WDG_ERR_BIT] = wdg_err_reg;
      stat[ssc_pkg::ST_DCDC_BIT] = dcdc_s;
   end

   // Snapshot follows status while idle and freezes for the frame, so the
   // shift logic reads a word that cannot change under it
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         snap_reg <= '0;
      end else if (cs_n_s) begin
         snap_reg <= stat;
      end
   end

   // Status bits first, then the received bits for a daisy chain
   always_comb begin
      if (frame_new_reg) begin
         O_DO = snap_reg[0];
      end else if (rx_cnt_reg == ssc_pkg::FULL_CNT) begin
         O_DO = rx_sr_reg[0];
      end else begin
         O_DO = snap_reg[rx_cnt_reg[3:0]];
      end
   end

   assign O_DO_OE = !I_CS_N; // Released as soon as deselected

   // ---------------- Outputs
   assign O_ERR_N = !err_reg;
   assign O_CTRL_WORD = ctrl_reg;
   assign O_TRK_EN = ctrl_reg[ssc_pkg::CTL_TRK_LSB+:ssc_pkg::TRK_N];
   assign O_RESET_DELAY_MS = dly_reg;
   assign O_WIN_MS = win_reg;
   assign O_WDG_EN = wdg_en_reg;
   assign O_WDG_ERR = wdg_err_reg;
endmodule : supply_spi_control_status
`default_nettype wire

// file: verif/ssc_supply_monitor.sv
// Port-level assertion checker for the supply SPI control and status block
`timescale 1ns/1ps
`default_nettype none
module ssc_supply_monitor (
   input wire logic I_CLK,                         // Core clock
   input wire logic I_RST_N,                       // Async reset, active low
   input wire logic I_CS_N,                        // Chip select
   input wire logic I_OVERTEMP,                    // Prewarning input
   input wire logic O_DO_OE,                       // Data out drive enable
   input wire logic O_ERR_N,                       // Fault pin
   input wire logic [ssc_pkg::WORD_W-1:0] O_CTRL_WORD, // Control word
   input wire logic [ssc_pkg::MS_W-1:0] O_RESET_DELAY_MS, // Reset delay
   input wire logic [ssc_pkg::MS_W-1:0] O_WIN_MS,  // Window time
   input wire logic O_WDG_EN,                      // Watchdog running
   input wire logic O_WDG_ERR                      // Watchdog error
);
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_N);

   // Decoded times follow the stored code one cycle later
   res_decode_a: assert property (
      O_RESET_DELAY_MS == (8'h40 >> {$past(O_CTRL_WORD[11]), $past(O_CTRL_WORD[10])}))
      else $error("reset delay decode wrong");
   win_decode_a: assert property (
      O_WIN_MS == (8'h80 >> {$past(O_CTRL_WORD[13]), $past(O_CTRL_WORD[12])}))
      else $error("window decode wrong");
   // Any pattern but 0,1,0 must keep the watchdog off
   wdg_gate_a: assert property (
      O_WDG_EN == (!$past(O_CTRL_WORD[0]) && $past(O_CTRL_WORD[9])
                   && !$past(O_CTRL_WORD[14])))
      else $error("watchdog enable decode wrong");
   spare_ignored_a: assert property (O_CTRL_WORD[1] == 1'h0)
      else $error("spare control bit stored");
   do_release_a: assert property (O_DO_OE == !I_CS_N)
      else $error("data out drive not tied to select");
   // Two synchroniser stages mean select was high two edges before a change
   ctrl_at_cs_a: assert property ($changed(O_CTRL_WORD) |-> $past(I_CS_N, 2))
      else $error("control word changed inside a frame");
   temp_err_a: assert property (I_OVERTEMP [*4] |-> ##[0:3] !O_ERR_N)
      else $error("prewarning did not pull the fault pin");
   werr_pin_a: assert property (O_WDG_ERR [*2] |-> !O_ERR_N)
      else $error("watchdog error without fault pin");
   // The error pulse is two registers behind the enable that allowed it
   werr_only_en_a: assert property ($rose(O_WDG_ERR) |-> $past(O_WDG_EN, 2))
      else $error("watchdog error while disabled");
   // Main scenarios
   cover property ($rose(O_WDG_ERR));
   cover property ($changed(O_CTRL_WORD));
   cover property ($fell(O_ERR_N));
endmodule : ssc_supply_monitor

bind supply_spi_control_status ssc_supply_monitor u_port_chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
   .I_CS_N(I_CS_N), .I_OVERTEMP(I_OVERTEMP), .O_DO_OE(O_DO_OE), .O_ERR_N(O_ERR_N),
   .O_CTRL_WORD(O_CTRL_WORD), .O_RESET_DELAY_MS(O_RESET_DELAY_MS), .O_WIN_MS(O_WIN_MS),
   .O_WDG_EN(O_WDG_EN), .O_WDG_ERR(O_WDG_ERR));
`default_nettype wire

// file: verif/ssc_spi_master.sv
// SPI master model standing in for the microcontroller on the far side
`timescale 1ns/1ps
`default_nettype none
module ssc_spi_master (
   output logic o_sclk, // Shift clock, still between frames
   output logic o_cs_n, // Chip select, active low
   output logic o_di,   // Serial data to the device
   input wire logic i_do // Resolved data line from the device
);
   // Idle: deselected, clock low
   initial begin
      o_sclk = 1'h0;
      o_cs_n = 1'h1;
      o_di = 1'h0;
   end

   // One frame; the first offset keeps select edges off the core clock edge
   task automatic xfer(input logic [15:0] w, input int nb, output logic [15:0] st);
      st = 16'h0000;
      #1;
      o_cs_n = 1'h0;
      #30;
      for (int k = 0; k < nb; k++) begin
         o_di = w[k];
         #32;
         if (k < 16) st[k] = i_do;
         o_sclk = 1'h1;
         #32;
         o_sclk = 1'h0;
      end
      #11;
      o_cs_n = 1'h1;
      o_di = ~o_di; // Released line must not show a stale bit
      #30;
   endtask : xfer
endmodule : ssc_spi_master
`default_nettype wire

// file: verif/supply_spi_control_status_tb_top.sv
// Self-checking bench for the supply SPI control and status block
`timescale 1ns/1ps
`default_nettype none
module supply_spi_control_status_tb_top;
   localparam int SETTLE = 50;
   // Ordinary cases: word, live inputs, expected decodes
   typedef struct packed {
      logic [15:0] w;
      logic temp;
      logic [2:0] uv;
      logic [7:0] res;
      logic [7:0] win;
      logic en;
   } ssc_row_t;
   localparam ssc_row_t ROWS [5] = '{
      '{16'h41FF, 1'h0, 3'h1, 8'h40, 8'h80, 1'h0},
      '{16'h55FD, 1'h1, 3'h2, 8'h20, 8'h40, 1'h0},
      '{16'h2BF9, 1'h0, 3'h4, 8'h10, 8'h20, 1'h0},
      '{16'h3DFC, 1'h0, 3'h7, 8'h08, 8'h10, 1'h0},
      '{16'h43FC, 1'h0, 3'h0, 8'h40, 8'h80, 1'h0}};
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic overtemp = 1'h0;
   logic ram_a = 1'h0;
   logic ram_b = 1'h0;
   logic dcdc = 1'h1;
   logic [5:0] settled = 6'h3F;
   logic [2:0] uv = 3'h0;
   wire logic sclk, cs_n, di, do_w;
   logic do_pin, do_oe, err_n, wdg_en, wdg_err;
   logic [15:0] ctrl, st, prev, want;
   logic [5:0] trk_en;
   logic [7:0] res_ms, win_ms;
   int n_errors = 0;
   int n_compared = 0;
   int n;

   always #2.5 clk = ~clk;
   assign do_w = do_oe ? do_pin : 1'hz; // Line floats when released

   supply_spi_control_status #(.CYC_PER_MS(20), .SETTLE_CYC(SETTLE)) dut (.I_CLK(clk),
      .I_RST_N(rst_n), .I_SCLK(sclk), .I_CS_N(cs_n), .I_DI(di), .O_DO(do_pin),
      .O_DO_OE(do_oe), .I_OVERTEMP(overtemp), .I_TRK_SETTLED(settled), .I_RAM_LOST_A(ram_a),
      .I_RAM_LOST_B(ram_b), .I_UV_RESET(uv), .I_DCDC_ON(dcdc), .O_ERR_N(err_n),
      .O_CTRL_WORD(ctrl), .O_TRK_EN(trk_en), .O_RESET_DELAY_MS(res_ms), .O_WIN_MS(win_ms),
      .O_WDG_EN(wdg_en), .O_WDG_ERR(wdg_err));
   ssc_spi_master mst (.o_sclk(sclk), .o_cs_n(cs_n), .o_di(di), .i_do(do_w));

   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   // A whole frame, then time for the word to cross and decode
   task automatic frame(input logic [15:0] w, input int nb);
      @(posedge clk);
      mst.xfer(w, nb, st);
      repeat (6) @(posedge clk);
   endtask : frame

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize

   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'h1;
      repeat (4) @(posedge clk);
      chk("ctrl", 16'h4DFD, ctrl);
      chk("decode", 16'h0880, {res_ms, win_ms});
      chk("pins", 16'h0000, {13'h0, wdg_en, wdg_err, err_n});
      frame(16'h4DFD, 16);
      chk("status", 16'h80FD, st);
      $display("reset test done");
      prev = 16'h4DFD;
      for (int i = 0; i < 5; i++) begin
         overtemp <= ROWS[i].temp;
         uv <= ROWS[i].uv;
         repeat (6) @(posedge clk);
         frame(ROWS[i].w, 16);
         want = {1'h1, 1'h0, ROWS[i].uv, 1'h0, 2'h3, prev[7:2], ROWS[i].temp, 1'h0};
         chk("status", want, st & 16'hFFFE);
         chk("ctrl", ROWS[i].w & 16'hFFFD, ctrl);
         chk("res", 16'(ROWS[i].res), 16'(res_ms));
         chk("win", 16'(ROWS[i].win), 16'(win_ms));
         chk("wdg_en", 16'(ROWS[i].en), 16'(wdg_en));
         chk("trk_en", 16'(ROWS[i].w[7:2]), 16'(trk_en));
         prev = ROWS[i].w;
         $display("row %0d done", i);
      end
      chk("err_clear", 16'h0001, 16'(err_n));
      // Tracker 0 enabled but never settles
      settled <= 6'h3E;
      n = 0;
      while (err_n === 1'h1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      if (n == 200) begin
         n_errors++;
         summarize();
      end
      chk("settle_time", 16'h0001, 16'(n >= SETTLE && n <= SETTLE + 8));
      frame(16'h43FC, 16);
      chk("trk_fail", 16'h0001, st & 16'h0007);
      settled <= 6'h3F;
      repeat (6) @(posedge clk);
      frame(16'h43FC, 16);
      chk("err_clear", 16'h0001, 16'(err_n));
      $display("tracker test done");
      // Watchdog on, then a trigger inside the closed window
      frame(16'h33FC, 16);
      chk("wdg_on", 16'h1001, {win_ms, 7'h00, wdg_en} & 16'h1001);
      frame(16'hB3FC, 16);
      chk("phase", 16'h0001, 16'(st[10]));
      chk("wdg_err", 16'h0003, {14'h0, wdg_err, !err_n});
      frame(16'h33FC, 16);
      chk("st_err", 16'h4001, st & 16'h4001);
      $display("watchdog test done");
      // Cold start flags, then cold start of the main regulator
      ram_b <= 1'h1;
      repeat (6) @(posedge clk);
      ram_b <= 1'h0;
      repeat (6) @(posedge clk);
      frame(16'h33FC, 16);
      chk("cold_b", 16'h0100, st & 16'h0300);
      frame(16'h33FC, 16);
      chk("warm", 16'h0300, st & 16'h0300);
      ram_a <= 1'h1;
      repeat (6) @(posedge clk);
      chk("ctrl_cold", 16'h4DFD, ctrl);
      ram_a <= 1'h0;
      repeat (6) @(posedge clk);
      // Short frame is refused and keeps the cold flag
      frame(16'h3DFC, 8);
      chk("short", 16'h4DFD, ctrl);
      frame(16'h4DFD, 16);
      chk("cold_a", 16'h0000, st & 16'h0100);
      $display("cold start test done");
      summarize();
   end
endmodule : supply_spi_control_status_tb_top
`default_nettype wire
